// ---- logic/ipss_image_port.sv ----
// Image port output signal selection, clipping, byte order and polarity.
// Assumes the back-end clock and every video and FIFO input change on that clock,
// and that a serial-bus front end delivers register writes as one-cycle strobes.
//
// Notes on behaviour
// RULE_01 - Pin 0 selector {fifoctl[5],sigsel[7:6]}: 011 low, 100 almost filled, 101 overflow.
// RULE_02 - Pin 0 codes 110 and 111 give almost full and almost empty, levels set in fifoctl.
// RULE_03 - Pin 0 codes 000, 001 and 010 give field ID, A/B task flag and sliced-data frame.
// RULE_04 - Pin 1 selector {fifoctl[4],sigsel[5:4]}: 000..011 give field ID, task, sliced, low.
// RULE_05 - Pin 1 codes 100..111 give almost filled, overflow, almost full, almost empty.
// RULE_06 - Horizontal pin by sigsel[1:0]: gate, extended gate, or trigger pulses.
// RULE_07 - Extended H gate is the output gate while active, else the input H reference.
// RULE_08 - Trigger modes pulse on the rising edge of the H gate or extended H gate.
// RULE_09 - Vertical pin by sigsel[3:2]: V gate, input V reference, or pulses from either.
// RULE_10 - Bit fmtpol[5] clips video to 1..254 when clear and to 8..247 when set.
// RULE_11 - Bits fmtpol[7:6] reorder the double word as 0123, 1032, 2301 or 3210.
// RULE_12 - Bit fmtpol[0] inverts the data qualifier pin when set.
// RULE_13 - Bit fmtpol[1] inverts the horizontal reference pin when set.
// RULE_14 - Bit fmtpol[2] inverts the vertical reference pin when set.
// RULE_15 - Bits fmtpol[3] and fmtpol[4] invert general-purpose pins 1 and 0 when set.
// RULE_16 - The qualifier pin carries valid data or a gated back-end clock, per a select bit.
// RULE_17 - Each inversion is applied after source selection, constant low included.
`timescale 1ns/1ps
module ipss_image_port
    import ipss_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rstn,
    // Register access.
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // Back-end clock and qualifier mode.
    input  wire logic        back_clk,
    input  wire logic        gated_clk_sel,
    // Flag sources.
    input  wire logic        field_id,
    input  wire logic        task_flag,
    input  wire logic        sliced_frame,
    input  wire logic        fifo_filled,
    input  wire logic        fifo_overflow,
    input  wire logic [5:0]  fifo_level,
    // Scaler reference sources.
    input  wire logic        h_gate,
    input  wire logic        h_ref_in,
    input  wire logic        scaler_active,
    input  wire logic        v_gate,
    input  wire logic        v_ref_in,
    // Video data.
    input  wire logic        data_valid,
    input  wire logic        code_word,
    input  wire logic [31:0] data_in,
    // Port pins.
    output logic             gp_flag_pin0,
    output logic             gp_flag_pin1,
    output logic             horiz_ref_pin,
    output logic             vert_ref_pin,
    output logic             data_qualifier_pin,
    output logic      [31:0] data_out
);

    localparam int SYNC_W = 52;

    logic [7:0]        sigsel_q;
    logic [7:0]        fmtpol_q;
    logic [7:0]        fifoctl_q;
    logic [7:0]        rdata_d;
    logic [SYNC_W-1:0] sync_s;
    logic              bclk_s;
    logic              gsel_s;
    logic              bclk_d1_q;
    logic              bfall;
    logic [31:0]       data_s;
    logic [5:0]        level_s;
    logic              hgate_s, href_s, act_s, vgate_s, vref_s, valid_s, code_s;
    logic              fid_s, task_s, slice_s, filled_s, ovf_s;
    logic              hgate_prev_q, hext_prev_q, vgate_prev_q, vref_prev_q;
    logic              valid_cap_q;
    logic              hext, afull, aempty;
    logic [2:0]        p0_sel, p1_sel;
    logic [7:0]        clip_lo, clip_hi;
    logic [7:0]        flags;
    logic              h_src, v_src, q_src;
    logic [31:0]       clipped, ordered;

    // All outside inputs except register access, the back-end clock and mode pin included, share one delay.
    ipss_sync #(
        .W (SYNC_W)
    ) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .din  ({gated_clk_sel, back_clk, field_id, task_flag, sliced_frame, fifo_filled,
                fifo_overflow, fifo_level, h_gate, h_ref_in, scaler_active, v_gate, v_ref_in,
                data_valid, code_word, data_in}),
        .dout (sync_s)
    );

    assign {gsel_s, bclk_s, fid_s, task_s, slice_s, filled_s, ovf_s, level_s, hgate_s,
            href_s, act_s, vgate_s, vref_s, valid_s, code_s, data_s} = sync_s;

    // Inputs launch on the rising back-end edge, so the falling edge sees them settled.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bclk_d1_q <= 1'b0;
        end else begin
            bclk_d1_q <= bclk_s;
        end
    end

    assign bfall = bclk_d1_q & ~bclk_s;

    // Register file.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sigsel_q  <= SIGSEL_RST;
            fmtpol_q  <= FMTPOL_RST;
            fifoctl_q <= FIFOCTL_RST;
        end else if (reg_wr) begin
            if (reg_addr == SIGSEL_ADDR) begin
                sigsel_q <= reg_wdata;
            end else if (reg_addr == FMTPOL_ADDR) begin
                fmtpol_q <= reg_wdata;
            end else if (reg_addr == FIFOCTL_ADDR) begin
                fifoctl_q <= reg_wdata;
            end
        end
    end

    always_comb begin
        if (reg_addr == SIGSEL_ADDR) begin
            rdata_d = sigsel_q;
        end else if (reg_addr == FMTPOL_ADDR) begin
            rdata_d = fmtpol_q;
        end else if (reg_addr == FIFOCTL_ADDR) begin
            rdata_d = fifoctl_q;
        end else begin
            rdata_d = 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

    // FIFO level flags.
    always_comb begin
        case (fifoctl_q[EMPTY_LVL_LSB +: 2])
            2'b00:   aempty = level_s < EMPTY_LT_16; // RULE_02
            2'b01:   aempty = level_s < EMPTY_LT_8;
            2'b10:   aempty = level_s < EMPTY_LT_4;
            default: aempty = level_s == 6'h00;
        endcase
        case (fifoctl_q[FULL_LVL_LSB +: 2])
            2'b00:   afull = level_s >= FULL_GE_16; // RULE_02
            2'b01:   afull = level_s >= FULL_GE_24;
            2'b10:   afull = level_s >= FULL_GE_28;
            default: afull = level_s == FULL_EQ_32;
        endcase
    end

    // Flag sources indexed by selector code.
    assign flags = {aempty, afull, ovf_s, filled_s, 1'b0, slice_s, task_s, fid_s}; // RULE_03
    assign p0_sel = {fifoctl_q[P0SEL_MSB_BIT], sigsel_q[P0SEL_LSB +: 2]}; // RULE_01
    assign p1_sel = {fifoctl_q[P1SEL_MSB_BIT], sigsel_q[P1SEL_LSB +: 2]}; // RULE_04
    assign hext   = act_s ? hgate_s : href_s; // RULE_07

    always_comb begin
        case (ipss_hform_t'(sigsel_q[HFORM_LSB +: 2]))
            HF_GATE:     h_src = hgate_s; // RULE_06
            HF_EXT:      h_src = hext;
            HF_TRIG:     h_src = hgate_s & ~hgate_prev_q; // RULE_08
            default:     h_src = hext & ~hext_prev_q;
        endcase
        case (ipss_vform_t'(sigsel_q[VFORM_LSB +: 2]))
            VF_GATE:     v_src = vgate_s; // RULE_09
            VF_REF:      v_src = vref_s;
            VF_TRIG:     v_src = vgate_s & ~vgate_prev_q;
            default:     v_src = vref_s & ~vref_prev_q;
        endcase
    end

    // Clip range and byte order.
    assign clip_lo = fmtpol_q[CLIPSEL_BIT] ? CLIP_NARROW_LO : CLIP_WIDE_LO; // RULE_10
    assign clip_hi = fmtpol_q[CLIPSEL_BIT] ? CLIP_NARROW_HI : CLIP_WIDE_HI;

    // Timing codes pass unclipped; they must keep their 00 and FF values.
    for (genvar b = 0; b < 4; b++) begin : g_clip
        always_comb begin
            if (code_s) begin
                clipped[8*b +: 8] = data_s[8*b +: 8];
            end else if (data_s[8*b +: 8] < clip_lo) begin
                clipped[8*b +: 8] = clip_lo; // RULE_10
            end else if (data_s[8*b +: 8] > clip_hi) begin
                clipped[8*b +: 8] = clip_hi;
            end else begin
                clipped[8*b +: 8] = data_s[8*b +: 8];
            end
        end
    end

    // Byte k of the output takes source byte k XOR the order code.
    for (genvar k = 0; k < 4; k++) begin : g_order
        localparam logic [1:0] K = 2'(k);
        assign ordered[8*k +: 8] = clipped[8*(K ^ fmtpol_q[ORDER_LSB +: 2]) +: 8]; // RULE_11
    end

    // Back-end rate state: edge history and pin updates.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hgate_prev_q <= 1'b0;
            hext_prev_q  <= 1'b0;
            vgate_prev_q <= 1'b0;
            vref_prev_q  <= 1'b0;
            valid_cap_q  <= 1'b0;
        end else if (bfall) begin
            hgate_prev_q <= hgate_s;
            hext_prev_q  <= hext;
            vgate_prev_q <= vgate_s;
            vref_prev_q  <= vref_s;
            valid_cap_q  <= valid_s;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gp_flag_pin0  <= 1'b0;
            gp_flag_pin1  <= 1'b0;
            horiz_ref_pin <= 1'b0;
            vert_ref_pin  <= 1'b0;
            data_out      <= 32'h00000000;
        end else if (bfall) begin
            gp_flag_pin0  <= flags[p0_sel] ^ fmtpol_q[P0INV_BIT]; // RULE_01 RULE_15 RULE_17
            gp_flag_pin1  <= flags[p1_sel] ^ fmtpol_q[P1INV_BIT]; // RULE_05 RULE_15 RULE_17
            horiz_ref_pin <= h_src ^ fmtpol_q[HINV_BIT]; // RULE_13
            vert_ref_pin  <= v_src ^ fmtpol_q[VINV_BIT]; // RULE_14
            data_out      <= ordered;
        end
    end

    // The gated form follows the sampled back-end clock every system cycle.
    assign q_src = gsel_s ? (valid_cap_q & bclk_s) : valid_cap_q; // RULE_16

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data_qualifier_pin <= 1'b0;
        end else begin
            data_qualifier_pin <= q_src ^ fmtpol_q[QINV_BIT]; // RULE_12 RULE_17
        end
    end

    pin0_low_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_01
        bfall && p0_sel == 3'b011 |=> gp_flag_pin0 == $past(fmtpol_q[P0INV_BIT]))
        else $error("pin 0 not constant low under selector 011");

    pin0_aempty_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_02
        bfall && p0_sel == 3'b111 && fifoctl_q[1:0] == 2'b11 && !fmtpol_q[P0INV_BIT]
        |=> gp_flag_pin0 == ($past(level_s) == 6'h00))
        else $error("pin 0 almost empty flag wrong");

    pin0_field_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_03
        bfall && p0_sel == 3'b000 |=> gp_flag_pin0 == ($past(fid_s) ^ $past(fmtpol_q[4])))
        else $error("pin 0 does not follow field ID");

    pin1_task_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_04
        bfall && p1_sel == 3'b001 |=> gp_flag_pin1 == ($past(task_s) ^ $past(fmtpol_q[3])))
        else $error("pin 1 does not follow task flag");

    pin1_overflow_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_05
        bfall && p1_sel == 3'b101 |=> gp_flag_pin1 == ($past(ovf_s) ^ $past(fmtpol_q[3])))
        else $error("pin 1 does not follow overflow");

    horiz_ext_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_07
        bfall && sigsel_q[1:0] == 2'b01 && !act_s && !fmtpol_q[HINV_BIT]
        |=> horiz_ref_pin == $past(href_s))
        else $error("extended H gate ignores input reference");

    horiz_trig_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_08
        bfall && sigsel_q[1:0] == 2'b10 && !fmtpol_q[HINV_BIT] && hgate_prev_q
        |=> !horiz_ref_pin)
        else $error("horizontal trigger without a rising gate");

    vert_ref_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_09 RULE_14
        bfall && sigsel_q[3:2] == 2'b01 |=> vert_ref_pin == ($past(vref_s) ^ $past(fmtpol_q[2])))
        else $error("vertical pin does not follow input reference");

    clip_range_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_10
        bfall && !code_s && fmtpol_q[7:5] == 3'b001
        |=> data_out[7:0] >= 8'h08 && data_out[7:0] <= 8'hf7)
        else $error("narrow clip range violated");

    byte_swap_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_11
        bfall && code_s && fmtpol_q[7:6] == 2'b11 |=> data_out[7:0] == $past(data_s[31:24]))
        else $error("full reverse byte order wrong");

    qual_invert_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_12 RULE_16
        !gsel_s |=> data_qualifier_pin == ($past(valid_cap_q) ^ $past(fmtpol_q[0])))
        else $error("qualifier polarity wrong");

    horiz_inv_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_13
        bfall && sigsel_q[1:0] == 2'b00 |=> horiz_ref_pin == ($past(hgate_s) ^ $past(fmtpol_q[1])))
        else $error("horizontal polarity wrong");

endmodule // ipss_image_port

// ---- logic/ipss_pkg.sv ----
// Package for the image port signal select block.
// Holds register offsets, field positions, reset values, clip limits and FIFO levels.
package ipss_pkg;

    // Register offsets.
    localparam logic [7:0] SIGSEL_ADDR   = 8'h84;
    localparam logic [7:0] FMTPOL_ADDR   = 8'h85;
    localparam logic [7:0] FIFOCTL_ADDR  = 8'h86;

    // Reset values.
    localparam logic [7:0] SIGSEL_RST    = 8'h00;
    localparam logic [7:0] FMTPOL_RST    = 8'h00;
    localparam logic [7:0] FIFOCTL_RST   = 8'h00;

    // Signal select register fields.
    localparam int HFORM_LSB     = 0;
    localparam int VFORM_LSB     = 2;
    localparam int P1SEL_LSB     = 4;
    localparam int P0SEL_LSB     = 6;

    // Format and polarity register fields.
    localparam int QINV_BIT      = 0;
    localparam int HINV_BIT      = 1;
    localparam int VINV_BIT      = 2;
    localparam int P1INV_BIT     = 3;
    localparam int P0INV_BIT     = 4;
    localparam int CLIPSEL_BIT   = 5;
    localparam int ORDER_LSB     = 6;

    // FIFO flag control register fields.
    localparam int EMPTY_LVL_LSB = 0;
    localparam int FULL_LVL_LSB  = 2;
    localparam int P1SEL_MSB_BIT = 4;
    localparam int P0SEL_MSB_BIT = 5;

    // Clip limits.
    localparam logic [7:0] CLIP_WIDE_LO   = 8'h01;
    localparam logic [7:0] CLIP_WIDE_HI   = 8'hfe;
    localparam logic [7:0] CLIP_NARROW_LO = 8'h08;
    localparam logic [7:0] CLIP_NARROW_HI = 8'hf7;

    // FIFO fill levels in double words.
    localparam int FIFO_LVL_W = 6;
    localparam logic [5:0] EMPTY_LT_16 = 6'h10;
    localparam logic [5:0] EMPTY_LT_8  = 6'h08;
    localparam logic [5:0] EMPTY_LT_4  = 6'h04;
    localparam logic [5:0] FULL_GE_16  = 6'h10;
    localparam logic [5:0] FULL_GE_24  = 6'h18;
    localparam logic [5:0] FULL_GE_28  = 6'h1c;
    localparam logic [5:0] FULL_EQ_32  = 6'h20;

    typedef enum logic [2:0] {
        GP_FIELD_ID = 3'b000,
        GP_TASK     = 3'b001,
        GP_SLICED   = 3'b010,
        GP_LOW      = 3'b011,
        GP_FILLED   = 3'b100,
        GP_OVERFLOW = 3'b101,
        GP_AFULL    = 3'b110,
        GP_AEMPTY   = 3'b111
    } ipss_gpsel_t;

    typedef enum logic [1:0] {
        HF_GATE     = 2'b00,
        HF_EXT      = 2'b01,
        HF_TRIG     = 2'b10,
        HF_EXT_TRIG = 2'b11
    } ipss_hform_t;

    typedef enum logic [1:0] {
        VF_GATE     = 2'b00,
        VF_REF      = 2'b01,
        VF_TRIG     = 2'b10,
        VF_REF_TRIG = 2'b11
    } ipss_vform_t;

endpackage

// ---- logic/ipss_sync.sv ----
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a level that is stable across several clk periods.
`timescale 1ns/1ps
module ipss_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rstn,
    // Levels.
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end

endmodule // ipss_sync

// ---- tb/ipss_capture_model.sv ----
// Capture-side partner: supplies the back-end clock and latches the port word.
// Assumes the port word changes only on the system clock, well away from this clock's rise.
`timescale 1ns/1ps
module ipss_capture_model (
    // Back-end clock.
    output logic             back_clk,
    // Port word in and captured copy out.
    input  wire logic [31:0] data_out,
    output logic      [31:0] cap_word
);
    // The back-end clock runs free; its phase is offset from the system clock on purpose.
    initial begin
        back_clk = 1'b0;
        #13;
        forever #40 back_clk = ~back_clk;
    end

    always @(posedge back_clk) begin
        cap_word <= data_out;
    end
endmodule // ipss_capture_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the image port signal select block.
// Assumes the capture model makes the back-end clock; every other input is driven here.
`timescale 1ns/1ps
module tb_top import ipss_pkg::*;;
    logic        clk, rstn, reg_wr, back_clk, gated_clk_sel;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic        field_id, task_flag, sliced_frame, fifo_filled, fifo_overflow;
    logic [5:0]  fifo_level;
    logic        h_gate, h_ref_in, scaler_active, v_gate, v_ref_in, data_valid, code_word;
    logic [31:0] data_in, data_out, cap_word;
    logic        gp0, gp1, hpin, vpin, qpin;
    int          bad_count, samples_checked, cycles, sig, fmt, ffc;

    ipss_image_port ipss_image_port_i (
        .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .back_clk(back_clk),
        .gated_clk_sel(gated_clk_sel), .field_id(field_id), .task_flag(task_flag),
        .sliced_frame(sliced_frame), .fifo_filled(fifo_filled),
        .fifo_overflow(fifo_overflow), .fifo_level(fifo_level), .h_gate(h_gate),
        .h_ref_in(h_ref_in), .scaler_active(scaler_active), .v_gate(v_gate),
        .v_ref_in(v_ref_in), .data_valid(data_valid), .code_word(code_word),
        .data_in(data_in), .gp_flag_pin0(gp0), .gp_flag_pin1(gp1),
        .horiz_ref_pin(hpin), .vert_ref_pin(vpin), .data_qualifier_pin(qpin),
        .data_out(data_out)
    );

    ipss_capture_model ipss_capture_model_i (
        .back_clk(back_clk), .data_out(data_out), .cap_word(cap_word)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // A hang is cut short well beyond the fewer than a thousand cycles the tests need.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            $display("timeout reached");
            report_and_stop();
        end
    end

    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Three back-end rises guarantee a full sampled fall after any input change.
    task automatic settle();
        repeat (3) @(posedge back_clk);
        tick(2);
    endtask

    task automatic check(string name, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        tick(1);
    endtask

    task automatic rd(logic [7:0] a, logic [7:0] e);
        reg_addr = a;
        tick(1);
        check("rdata", e, reg_rdata);
    endtask

    task automatic setregs();
        wr(SIGSEL_ADDR, sig[7:0]);
        wr(FMTPOL_ADDR, fmt[7:0]);
        wr(FIFOCTL_ADDR, ffc[7:0]);
    endtask

    function automatic logic egp(int code, int inv);
        int   e;
        int   f;
        logic r;
        e = ffc & 3;
        f = (ffc >> 2) & 3;
        case (code)
            0: r = field_id;
            1: r = task_flag;
            2: r = sliced_frame;
            3: r = 1'b0;
            4: r = fifo_filled;
            5: r = fifo_overflow;
            6: r = (fifo_level >= (f == 0 ? 16 : f == 1 ? 24 : f == 2 ? 28 : 32));
            default: r = (fifo_level < (e == 0 ? 16 : e == 1 ? 8 : e == 2 ? 4 : 1));
        endcase
        return r ^ inv[0];
    endfunction

    function automatic logic [31:0] edata();
        int          lo;
        int          hi;
        int          b;
        logic [31:0] r;
        lo = fmt[5] ? 8 : 1;
        hi = fmt[5] ? 247 : 254;
        for (int k = 0; k < 4; k++) begin
            b = data_in[8 * (k ^ (fmt >> 6)) +: 8];
            if (!code_word) b = b < lo ? lo : (b > hi ? hi : b);
            r[8 * k +: 8] = b[7:0];
        end
        return r;
    endfunction

    initial begin
        rstn = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        gated_clk_sel = 1'b0;
        {field_id, task_flag, sliced_frame, fifo_filled, fifo_overflow} = 5'h00;
        {h_gate, h_ref_in, scaler_active, v_gate, v_ref_in, data_valid} = 6'h00;
        fifo_level = 6'h00;
        code_word = 1'b0;
        data_in = 32'h00000000;
        void'($urandom(88));
        tick(6);
        rstn = 1'b1;
        tick(1);

        rd(SIGSEL_ADDR, SIGSEL_RST);
        rd(FMTPOL_ADDR, FMTPOL_RST);
        rd(FIFOCTL_ADDR, FIFOCTL_RST);
        wr(8'h87, 8'hff);
        rd(8'h87, 8'h00);
        $display("test registers done");

        for (int j = 0; j < 2; j++) begin
            for (int c = 0; c < 8; c++) begin
                sig = ((c & 3) << 6) | (((7 - c) & 3) << 4) | (((c >> 1) & 1) << 2) | (c & 1);
                ffc = ((c >> 2) << 5) | (((7 - c) >> 2) << 4) | $urandom_range(15, 0);
                fmt = ((c & 3) << 6) | ((c >> 2) << 5) | $urandom_range(31, 0);
                if (c == 7 && j == 0) begin
                    ffc = ffc | 3;
                    fmt = fmt & 8'hef;
                end
                setregs();
                rd(FMTPOL_ADDR, fmt[7:0]);
                {field_id, task_flag, sliced_frame, fifo_filled, fifo_overflow, h_gate,
                    h_ref_in, scaler_active, v_gate, v_ref_in, data_valid} = 11'($urandom());
                fifo_level = 6'($urandom_range(32, 0));
                data_in = c[0] ? $urandom() : 32'hfff80700;
                code_word = (j == 1) && (c == 7 || $urandom_range(1, 0) == 1);
                gated_clk_sel = j[0];
                settle();
                check("gp0", egp(c, (fmt >> 4) & 1), gp0);
                check("gp1", egp(7 - c, (fmt >> 3) & 1), gp1);
                check("horiz", ((c & 1) ? (scaler_active ? h_gate : h_ref_in) : h_gate)
                    ^ fmt[1], hpin);
                check("vert", (c[1] ? v_ref_in : v_gate) ^ fmt[2], vpin);
                check("qual", (j == 0 && data_valid) ^ fmt[0], qpin);
                check("data", edata(), data_out);
                check("capture", edata(), cap_word);
                if (j == 1) begin
                    tick(2);
                    check("qual gated", data_valid ^ fmt[0], qpin);
                end
            end
        end
        $display("test selection, clipping and order done");

        for (int m = 0; m < 4; m++) begin
            sig = 8 | ((m >> 1) << 2) | 2 | (m & 1);
            fmt = m << 1;
            ffc = 0;
            setregs();
            {h_gate, h_ref_in, scaler_active, v_gate, v_ref_in} = 5'h00;
            settle();
            check("horiz idle", fmt[1], hpin);
            check("vert idle", fmt[2], vpin);
            @(posedge back_clk);
            tick(1);
            if (m & 1) h_ref_in = 1'b1;
            else h_gate = 1'b1;
            if (m >> 1) v_ref_in = 1'b1;
            else v_gate = 1'b1;
            @(posedge back_clk);
            tick(2);
            check("horiz pulse", !fmt[1], hpin);
            check("vert pulse", !fmt[2], vpin);
            @(posedge back_clk);
            tick(2);
            check("horiz after", fmt[1], hpin);
            check("vert after", fmt[2], vpin);
        end
        $display("test trigger pulses done");
        report_and_stop();
    end
endmodule // tb_top
